// [hdl/ads_regs.svh]
`ifndef ADS_REGS_SVH
`define ADS_REGS_SVH
`define ADS_CLK_NS 10
`define ADS_TICK_NS 1000
`define ADS_SS_US 8200
`define ADS_TRANS_US 60
`define ADS_DG_US 4
`define ADS_WAKE_PERIODS 3
`define ADS_UV_RETRIES 3
`define ADS_CNT_W 24
`define ADS_DIV_W 8
`define ADS_DG_W 4
`define ADS_RAMP_W 8
`define ADS_ADDR_W 8
`define ADS_REG_CTRL 8'h00
`define ADS_REG_STATUS 8'h04
`define ADS_CTRL_KEEP5V_BIT 0
`define ADS_CTRL_KEEP5V_RESET 1'b0
`endif

// [hdl/ads_pkg.sv]
`default_nettype none
`include "ads_regs.svh"
package ads_pkg;
	typedef enum logic [2:0] {
		ADS_INIT = 3'h0,
		ADS_RAMP = 3'h1,
		ADS_SLEEP = 3'h3,
		ADS_WAKE = 3'h2,
		ADS_ACTIVE = 3'h6,
		ADS_SUSDLY = 3'h7,
		ADS_UVOFF = 3'h5,
		ADS_LATCH = 3'h4
	} ads_state_e;
	typedef enum logic [1:0] {
		ADS_CMD_ACTIVE = 2'h0,
		ADS_CMD_SUSPEND = 2'h1,
		ADS_CMD_SOFTOFF = 2'h2,
		ADS_CMD_INVALID = 2'h3
	} ads_cmd_e;
	typedef logic [`ADS_CNT_W-1:0] ads_cnt_t;
	typedef struct packed {
		ads_state_e st;
		logic softoff;
		logic booted;
		ads_cnt_t cnt;
		logic [`ADS_DIV_W-1:0] div;
		logic [1:0] pair;
		logic [`ADS_DG_W-1:0] dg;
		logic [1:0] retries;
		logic latched;
		logic keep5v;
		logic [31:0] rdata;
	} ads_seq_s;
endpackage : ads_pkg
`default_nettype wire

// [hdl/ads_sync.sv]
`default_nettype none
module ads_sync #(
	parameter int N = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins in, filtered levels out
	input wire logic [N-1:0] raw,
	output logic [N-1:0] level
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
		logic [N-1:0] lvl;
	} ads_sync_s;
	ads_sync_s q, d;
	logic [N-1:0] agree;
	always_comb
	begin
		agree = ~(q.s2 ^ q.s3);
		d.s1 = raw;
		d.s2 = q.s1;
		d.s3 = q.s2;
		// only s2 and s3 are compared; s1 may still be metastable
		d.lvl = (q.lvl & ~agree) | (q.s3 & agree);
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			q <= '0;
		else
			q <= d;
	end
	assign level = q.lvl;
endmodule : ads_sync
`default_nettype wire

// [hdl/ads_sequencer.sv]
`default_nettype none
`include "ads_regs.svh"
module ads_sequencer
	import ads_pkg::*;
#(
	parameter int TICK_CYCLES = `ADS_TICK_NS / `ADS_CLK_NS,
	parameter int SS_TICKS = `ADS_SS_US * 1000 / `ADS_TICK_NS,
	parameter int TRANS_TICKS = `ADS_TRANS_US * 1000 / `ADS_TICK_NS,
	parameter int DG_TICKS = `ADS_DG_US * 1000 / `ADS_TICK_NS
) (
	// clock and power-on reset
	input wire logic clk,
	input wire logic rst,
	// sleep-state pins from the chipset
	input wire logic suspend_request_n,
	input wire logic softoff_request_n,
	// analogue comparators
	input wire logic twelve_volt_ok,
	input wire logic aux_rail_uv,
	// register port
	input wire logic [`ADS_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// nfet gate, open drain
	output logic nfet_gate_release_o,
	output logic nfet_gate_release_oe,
	// pfet gate
	output logic pfet_gate_drive_o,
	output logic pfet_gate_drive_oe,
	output logic pfet_soft_sink,
	// auxiliary linear regulator
	output logic aux_ldo_enable,
	output logic aux_ldo_standby,
	output logic [`ADS_RAMP_W-1:0] aux_ldo_ref
);
	localparam ads_cnt_t SS_N = `ADS_CNT_W'(SS_TICKS);
	localparam ads_cnt_t WAKE_N = `ADS_CNT_W'(`ADS_WAKE_PERIODS * SS_TICKS);
	localparam ads_cnt_t TRANS_N = `ADS_CNT_W'(TRANS_TICKS);
	localparam logic [`ADS_DG_W-1:0] DG_N = `ADS_DG_W'(DG_TICKS);
	localparam logic [`ADS_DIV_W-1:0] DIV_N = `ADS_DIV_W'(TICK_CYCLES);
	localparam logic [1:0] RETRY_N = 2'(`ADS_UV_RETRIES);

	function automatic ads_cmd_e ads_decode(input logic [1:0] p);
		// p = {soft-off_n, suspend_n}
		unique case (p)
			2'b11: ads_decode = ADS_CMD_ACTIVE;
			2'b10: ads_decode = ADS_CMD_SUSPEND;
			2'b00: ads_decode = ADS_CMD_SOFTOFF;
			2'b01: ads_decode = ADS_CMD_INVALID;
		endcase
	endfunction : ads_decode

	function automatic logic [`ADS_RAMP_W-1:0] ads_ramp(input ads_cnt_t c);
		logic [`ADS_CNT_W+`ADS_RAMP_W-1:0] prod;
		prod = {c, {`ADS_RAMP_W{1'b0}}} / (`ADS_CNT_W+`ADS_RAMP_W)'(SS_TICKS);
		ads_ramp = prod[`ADS_RAMP_W-1:0];
	endfunction : ads_ramp

	ads_seq_s q, d;
	logic [3:0] sync_lvl;
	logic tick;
	logic twelve_s;
	logic uv_s;
	ads_cmd_e cmd;
	logic five_on;

	ads_sync #(
		.N(4)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.raw({aux_rail_uv, twelve_volt_ok, softoff_request_n, suspend_request_n}),
		.level(sync_lvl)
	);

	assign twelve_s = sync_lvl[2];
	assign uv_s = sync_lvl[3];
	assign tick = (q.div == DIV_N - 1'b1);
	assign cmd = ads_decode(q.pair);

	function automatic logic ads_done(input ads_cnt_t c, input ads_cnt_t lim, input logic t);
		ads_done = t && (c == lim - 1'b1);
	endfunction : ads_done

	always_comb
	begin
		d = q;
		d.div = tick ? '0 : q.div + 1'b1;
		d.cnt = tick ? q.cnt + 1'b1 : q.cnt;
		// short pulses restart the stability count
		if (sync_lvl[1:0] == q.pair)
			d.dg = '0;
		else if (tick && q.dg == DG_N - 1'b1)
		begin
			d.pair = sync_lvl[1:0];
			d.dg = '0;
		end
		else if (tick)
			d.dg = q.dg + 1'b1;
		unique case (q.st)
			ADS_INIT:
				if (ads_done(q.cnt, SS_N, tick))
				begin
					d.st = ADS_RAMP;
					d.cnt = '0;
				end
			ADS_RAMP:
				if (ads_done(q.cnt, SS_N, tick))
				begin
					d.st = ADS_SLEEP;
					d.cnt = '0;
					d.booted = 1'b1;
					if (!q.booted && cmd == ADS_CMD_SUSPEND)
						d.softoff = 1'b0;
					else if (cmd == ADS_CMD_SOFTOFF)
						d.softoff = 1'b1;
				end
			ADS_SLEEP:
			begin
				d.cnt = '0;
				if (uv_s && q.booted)
				begin
					if (q.retries == RETRY_N)
					begin
						d.st = ADS_LATCH;
						d.latched = 1'b1;
					end
					else
					begin
						d.st = ADS_UVOFF;
						d.retries = q.retries + 1'b1;
					end
				end
				else if (cmd == ADS_CMD_ACTIVE)
					d.st = ADS_WAKE;
				else if (cmd == ADS_CMD_SOFTOFF)
					d.softoff = 1'b1;
				// suspend while in soft-off and invalid codes change nothing
			end
			ADS_WAKE:
			begin
				if (cmd == ADS_CMD_SOFTOFF || (cmd == ADS_CMD_SUSPEND && !q.softoff))
				begin
					d.st = ADS_SLEEP;
					d.cnt = '0;
					if (cmd == ADS_CMD_SOFTOFF)
						d.softoff = 1'b1;
				end
				else if (!twelve_s)
					d.cnt = '0;
				else if (ads_done(q.cnt, WAKE_N, tick))
				begin
					d.st = ADS_ACTIVE;
					d.cnt = '0;
				end
			end
			ADS_ACTIVE:
			begin
				d.cnt = '0;
				if (cmd == ADS_CMD_SOFTOFF)
				begin
					d.st = ADS_SLEEP;
					d.softoff = 1'b1;
				end
				else if (cmd == ADS_CMD_SUSPEND)
					d.st = ADS_SUSDLY;
			end
			ADS_SUSDLY:
				if (cmd == ADS_CMD_SOFTOFF)
				begin
					d.st = ADS_SLEEP;
					d.softoff = 1'b1;
					d.cnt = '0;
				end
				else if (cmd == ADS_CMD_ACTIVE)
				begin
					d.st = ADS_ACTIVE;
					d.cnt = '0;
				end
				else if (cmd == ADS_CMD_SUSPEND && ads_done(q.cnt, TRANS_N, tick))
				begin
					d.st = ADS_SLEEP;
					d.softoff = 1'b0;
					d.cnt = '0;
				end
			ADS_UVOFF:
				if (ads_done(q.cnt, SS_N, tick))
				begin
					d.st = ADS_RAMP;
					d.cnt = '0;
				end
			ADS_LATCH:
				d.cnt = '0;
		endcase
		if (reg_wr && reg_addr == `ADS_REG_CTRL)
			d.keep5v = reg_wdata[`ADS_CTRL_KEEP5V_BIT];
		d.rdata = '0;
		if (reg_rd && reg_addr == `ADS_REG_CTRL)
			d.rdata[`ADS_CTRL_KEEP5V_BIT] = q.keep5v;
		else if (reg_rd && reg_addr == `ADS_REG_STATUS)
			d.rdata[9:0] = {q.pair, twelve_s, q.latched, q.retries, q.softoff, q.st};
	end

	always_ff @(posedge clk or posedge rst)
	begin
		// rst is the standby supply monitor; all state restarts on it
		if (rst)
		begin
			q <= '0;
			q.st <= ADS_INIT;
			q.softoff <= 1'b1;
			q.keep5v <= `ADS_CTRL_KEEP5V_RESET;
		end
		else
			q <= d;
	end

	// 5 V dual rail stays on in suspend, or in soft-off with the option
	assign five_on = !q.softoff || q.keep5v;

	always_comb
	begin
		nfet_gate_release_o = 1'b0;
		nfet_gate_release_oe = 1'b1;
		pfet_gate_drive_o = 1'b1;
		pfet_gate_drive_oe = 1'b1;
		pfet_soft_sink = 1'b0;
		aux_ldo_enable = 1'b0;
		aux_ldo_standby = 1'b0;
		aux_ldo_ref = '0;
		unique case (q.st)
			ADS_INIT, ADS_UVOFF, ADS_LATCH:
				aux_ldo_enable = 1'b0;
			ADS_RAMP:
			begin
				aux_ldo_enable = 1'b1;
				aux_ldo_ref = ads_ramp(q.cnt);
				if (five_on)
				begin
					pfet_gate_drive_oe = 1'b0;
					pfet_soft_sink = 1'b1;
				end
			end
			ADS_SLEEP, ADS_WAKE:
			begin
				aux_ldo_enable = 1'b1;
				aux_ldo_ref = '1;
				pfet_gate_drive_o = !five_on;
			end
			ADS_ACTIVE, ADS_SUSDLY:
			begin
				// gate released: the 12 V pull-up turns the pass devices on
				nfet_gate_release_oe = 1'b0;
				aux_ldo_standby = 1'b1;
			end
		endcase
	end

	assign reg_rdata = q.rdata;

	default clocking ads_cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_INVALID_HOLDS: assert property (
		q.st == ADS_SLEEP && cmd == ADS_CMD_INVALID && !uv_s |=> q.st == ADS_SLEEP && $stable(q.softoff))
		else $error("invalid sleep code changed state");
	AST_NO_SOFTOFF_TO_SUSPEND: assert property (
		q.softoff && q.booted && q.st != ADS_SUSDLY |=> q.softoff)
		else $error("soft-off moved to suspend");
	AST_PFET_ON_SUSPEND: assert property (
		q.st == ADS_SLEEP && !q.softoff |-> pfet_gate_drive_oe && !pfet_gate_drive_o)
		else $error("pfet gate not on in suspend");
	AST_SUSPEND_DELAY: assert property (
		q.st == ADS_SLEEP && $past(q.st) == ADS_SUSDLY && !q.softoff |-> $past(q.cnt) == TRANS_N - 1'b1)
		else $error("suspend entered before delay");
	AST_SOFTOFF_NOW: assert property (
		q.st == ADS_ACTIVE && cmd == ADS_CMD_SOFTOFF |=> q.st == ADS_SLEEP && q.softoff)
		else $error("soft-off not immediate");
	AST_WAIT_TWELVE: assert property (
		q.st == ADS_WAKE && !twelve_s |=> q.st != ADS_ACTIVE)
		else $error("active without 12 V");
	AST_POR_INTERVAL: assert property (
		q.st == ADS_RAMP && $past(q.st) == ADS_INIT |-> $past(q.cnt) == SS_N - 1'b1 && $past(tick))
		else $error("ramp began early");
	AST_ACTIVE_OUTPUTS: assert property (
		q.st == ADS_ACTIVE |-> !nfet_gate_release_oe && pfet_gate_drive_o && pfet_gate_drive_oe && aux_ldo_standby)
		else $error("active outputs wrong");
	AST_UV_OFF: assert property (
		q.st == ADS_SLEEP && uv_s && q.retries != RETRY_N |=> q.st == ADS_UVOFF ##1 !aux_ldo_enable)
		else $error("undervoltage did not disable regulator");
	AST_LATCH_STAYS: assert property (
		q.latched |=> q.latched && q.st == ADS_LATCH && !aux_ldo_enable)
		else $error("latch released");
	COV_ACTIVE: cover property (q.st == ADS_WAKE ##1 q.st == ADS_ACTIVE);
	COV_SUSPEND: cover property (q.st == ADS_SUSDLY ##1 q.st == ADS_SLEEP && !q.softoff);
	COV_LATCH: cover property (q.st == ADS_SLEEP ##1 q.st == ADS_LATCH);
endmodule : ads_sequencer
`default_nettype wire

// [test/ads_chipset.sv]
`default_nettype none
module ads_chipset (
	// clock
	input wire logic clk,
	// wanted {softoff_n, suspend_n} and a one-cycle glitch
	input wire logic [1:0] want,
	input wire logic glitch,
	// sleep-state pins
	output logic suspend_request_n,
	output logic softoff_request_n
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {softoff_request_n, suspend_request_n} = 2'h0;
	// waking lifts soft-off a cycle before suspend, as a chipset does
	always @(posedge clk)
	begin
		if (want[1] && !softoff_request_n)
			softoff_request_n <= 1'b1;
		else
			{softoff_request_n, suspend_request_n} <= want ^ {1'b0, glitch};
	end
endmodule : ads_chipset
`default_nettype wire

// [test/test_ads_sequencer.sv]
`default_nettype none
module test_ads_sequencer;
	import ads_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, gl, tv, uv, wr, rd, noe, no, po, poe, sk, en, sb, sn, fn;
	logic [1:0] want;
	logic [7:0] ra, rf, r, rnd;
	logic [31:0] wd, rdat, d;
	logic m_kind, m_keep, m_lat;
	logic [1:0] m_ret;
	int n_mismatch, total_checks, cyc, t0, c, c1, n, k;
	ads_chipset u_ads_chipset (.clk(clk), .want(want), .glitch(gl), .suspend_request_n(sn),
		.softoff_request_n(fn));
	// short counts keep the run brief: interval is 8 cycles
	ads_sequencer #(.TICK_CYCLES(2), .SS_TICKS(4), .TRANS_TICKS(3), .DG_TICKS(2)) u_ads_sequencer (
		.clk(clk), .rst(rst), .suspend_request_n(sn), .softoff_request_n(fn), .twelve_volt_ok(tv),
		.aux_rail_uv(uv), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
		.nfet_gate_release_o(no), .nfet_gate_release_oe(noe), .pfet_gate_drive_o(po),
		.pfet_gate_drive_oe(poe), .pfet_soft_sink(sk), .aux_ldo_enable(en), .aux_ldo_standby(sb),
		.aux_ldo_ref(rf));
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test();
		if (n_mismatch == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	task automatic wreg(input logic [7:0] a, input logic [31:0] v);
		ra <= a;
		wd <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wreg
	task automatic rreg(input logic [7:0] a, output logic [31:0] v);
		ra <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdat;
	endtask : rreg
	task automatic till(ref logic sg, input logic v, output int cn);
		for (cn = 0; cn < 300 && sg !== v; cn++)
		begin
			@(posedge clk);
			#1;
		end
	endtask : till
	// poll the state, then hold pins and status against the model
	task automatic see(input logic [2:0] s);
		d = 32'hffff_ffff;
		for (int i = 0; i < 200 && d[2:0] !== s; i++)
			rreg(8'h04, d);
		chk({d[6:4], d[2:0]}, {m_lat, m_ret, s});
		chk({noe, no, en, sb}, {s != 3'h6, 1'b0, s > 3'h0 && s < 3'h4, s == 3'h6});
		if (s == 3'h3)
			chk({d[3], po, poe}, {m_kind, !(m_keep || !m_kind), 1'b1});
		if (s == 3'h6)
			chk({po, poe}, 2'h3);
	endtask : see
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			finish_test();
		end
	end
	initial
	begin
		{rst, gl, tv, uv, wr, rd, want, ra, wd, cyc} = '0;
		rst = 1'b1;
		{m_kind, m_keep, m_lat, m_ret} = 5'h10;
		rnd = 8'h49;
		repeat (12) @(posedge clk);
		#1 chk({noe, po, poe, sk, en, rf}, 13'h1c00);
		rst <= 1'b0;
		t0 = cyc;
		@(posedge clk);
		#1 rreg(8'h00, d);
		chk(d, 32'h0000_0000);
		rnd = lfsr(rnd);
		wreg(8'h40, {rnd, rnd, rnd, rnd});
		rreg(8'h40, d);
		chk(d, 32'h0000_0000);
		wreg(8'h00, 32'h0000_0001);
		m_keep = 1'b1;
		till(en, 1'b1, c);
		chk(cyc - t0 > 5 && cyc - t0 < 14, 1);
		r = rf;
		k = 0;
		for (n = 0; n < 99 && sk; n++)
		begin
			@(posedge clk);
			#1 k += int'(rf > r);
			r = rf;
		end
		chk(n > 5 && n < 11, 1);
		chk(k > 2, 1);
		see(3'h3);
		want <= 2'h2;
		repeat (40) @(posedge clk);
		see(3'h3);
		want <= 2'h3;
		repeat (60) @(posedge clk);
		chk(noe, 1'b1);
		tv <= 1'b1;
		till(noe, 1'b0, c);
		chk(c > 23 && c < 42, 1);
		see(3'h6);
		want <= 2'h1;
		gl <= 1'b1;
		uv <= 1'b1;
		@(posedge clk);
		gl <= 1'b0;
		repeat (40) @(posedge clk);
		uv <= 1'b0;
		see(3'h6);
		want <= 2'h3;
		@(posedge clk);
		want <= 2'h2;
		till(noe, 1'b1, c1);
		m_kind = 1'b0;
		see(3'h3);
		want <= 2'h3;
		till(noe, 1'b0, c);
		want <= 2'h0;
		till(noe, 1'b1, c);
		chk(c1 - c > 3, 1);
		m_kind = 1'b1;
		see(3'h3);
		for (int i = 0; i < 4; i++)
		begin
			rnd = lfsr(rnd);
			uv <= 1'b1;
			repeat (4 + rnd[1:0]) @(posedge clk);
			uv <= 1'b0;
			till(en, 1'b0, c);
			chk(c < 12, 1);
			if (i < 3)
			begin
				till(en, 1'b1, c);
				chk(c > 4 && c < 12, 1);
				m_ret++;
				see(3'h3);
			end
		end
		m_lat = 1'b1;
		repeat (40) @(posedge clk);
		see(3'h4);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		{m_lat, m_ret} = 3'h0;
		see(3'h0);
		finish_test();
	end
endmodule : test_ads_sequencer
`default_nettype wire
